// [pkg/ocd_pkg.sv]
// Summary of operation
// RQ1 VCO ticks feed two independent prescalers dividing by four, five or six.
// RQ2 Prescaler ratio fields sit at bits 4:3 and 6:5 of one register.
// RQ3 Four channels each own an integer divider with smooth ratio switching.
// RQ4 Two-bit select feeds each divider from prescaler a, b or reference.
// RQ5 One bypass bit per channel puts the reference clock straight out.
// RQ6 Output zero carries reference or phase detector clock, with path enable.
// RQ7 Divider ratio is fourteen bits in the low part of source register.
// RQ8 Outputs one and four offer single-ended, low-power HCSL and LVDS-like.
// RQ9 Outputs two and three offer only low-power HCSL and LVDS-like.
// RQ10 Software enables at most one buffer type per output at a time.
// RQ11 Outputs one and four have separate enables for positive, negative pins.
// RQ12 Each single-ended pin of outputs one and four has its own invert.
// RQ13 Output zero buffer has its own enable and a four-bit edge rate.
// RQ14 Single-ended buffers of outputs one and four get four-bit edge rates.
// RQ15 Each differential output has a low-power HCSL enable bit.
// RQ16 Each differential output has an LVDS-like enable bit.
// RQ17 Four-bit bias trim per channel sets LVDS-like swing and common mode.
// RQ18 Common mode raise and lower fields apply only in 2.5/3.3 V mode.
// RQ19 Software matches low supply flags to supply and sets safety mode.
// RQ20 Smooth update never cuts a high pulse; the low pulse stretches.
// RQ21 Software turns off unused clock paths to limit crosstalk.
// RQ22 Smooth update enable sits at bit 9 of each control register a.
// RQ23 Divider gives one output period per programmed count of source ticks.
package ocd_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam int NREG = 21;
   localparam int AW   = 7;
   localparam int DW   = 16;
   typedef logic [AW-1:0] ocd_addr_t;
   typedef logic [DW-1:0] ocd_word_t;
   typedef logic [NREG-1:0][DW-1:0] ocd_regs_t;

   localparam int IX_REF_ROUTE = 0;
   localparam int IX_PRESCALE  = 1;
   localparam int IX_CH1_SRC   = 2;
   localparam int IX_CH1_CTLA  = 3;
   localparam int IX_CH1_CTLB  = 4;
   localparam int IX_CH1_TRIM  = 5;
   localparam int IX_CH2_SRC   = 6;
   localparam int IX_CH2_CTLA  = 7;
   localparam int IX_CH2_CTLB  = 8;
   localparam int IX_CH2_TRIM  = 9;
   localparam int IX_CH3_SRC   = 10;
   localparam int IX_CH3_CTLA  = 11;
   localparam int IX_CH3_CTLB  = 12;
   localparam int IX_CH3_TRIM  = 13;
   localparam int IX_CH4_SRC   = 14;
   localparam int IX_CH4_CTLA  = 15;
   localparam int IX_CH4_CTLB  = 16;
   localparam int IX_CH4_TRIM  = 17;
   localparam int IX_CH4_TRIMB = 18;
   localparam int IX_OUTPUT_ZERO_EN   = 19;
   localparam int IX_OUTPUT_ZERO_SLEW = 20;

   localparam ocd_addr_t REG_ADDR [NREG] = '{
      7'h19, 7'h2f, 7'h38, 7'h39, 7'h3b, 7'h3c, 7'h3e, 7'h3f, 7'h41,
      7'h42, 7'h43, 7'h44, 7'h46, 7'h47, 7'h48, 7'h49, 7'h4b, 7'h4c,
      7'h4d, 7'h4e, 7'h4f};
   localparam ocd_word_t REG_RESET = 16'h0000;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int PSA_LSB      = 3;
   localparam int PSB_LSB      = 5;
   localparam int OUTPUT_ZERO_SRC_BIT = 9;
   localparam int OUTPUT_ZERO_PATH_BIT = 10;
   localparam int BYPASS_LSB   = 11;
   localparam int DIV_LSB      = 0;
   localparam int DIV_W        = 14;
   localparam int SRC_LSB      = 14;
   localparam int SMOOTH_BIT   = 9;
   localparam int OUTPUT_ZERO_ON_BIT  = 12;
   localparam int SLEW_LSB     = 0;

   localparam int NCH = 4;
   localparam int IX_SRC  [NCH] = '{IX_CH1_SRC, IX_CH2_SRC, IX_CH3_SRC,
                                    IX_CH4_SRC};
   localparam int IX_CTLA [NCH] = '{IX_CH1_CTLA, IX_CH2_CTLA, IX_CH3_CTLA,
                                    IX_CH4_CTLA};
   localparam int IX_CTLB [NCH] = '{IX_CH1_CTLB, IX_CH2_CTLB, IX_CH3_CTLB,
                                    IX_CH4_CTLB};
   localparam int IX_TRIM [NCH] = '{IX_CH1_TRIM, IX_CH2_TRIM, IX_CH3_TRIM,
                                    IX_CH4_TRIM};
   localparam int IX_CMDN [NCH] = '{IX_CH1_TRIM, IX_CH2_CTLB, IX_CH3_TRIM,
                                    IX_CH4_TRIMB};
   localparam int HCSL_BIT [NCH] = '{14, 13, 13, 13};
   localparam int LVDS_BIT [NCH] = '{15, 11, 11, 15};
   localparam int BIAS_LSB [NCH] = '{12, 0, 0, 6};
   localparam int CMUP_LSB [NCH] = '{10, 4, 4, 4};
   localparam int CMDN_LSB [NCH] = '{4, 13, 9, 0};
   localparam bit CMOS_OK  [NCH] = '{1'b1, 1'b0, 1'b0, 1'b1};
   localparam int PEN_BIT  [NCH] = '{13, 0, 0, 14};
   localparam int NEN_BIT  [NCH] = '{14, 0, 0, 13};
   localparam int PPOL_BIT [NCH] = '{11, 0, 0, 12};
   localparam int NPOL_BIT [NCH] = '{12, 0, 0, 11};

   // ****************************************
   // Encodings
   // ****************************************
   typedef enum logic [1:0] {
      PS_DIV4 = 2'b00,
      PS_DIV5 = 2'b01,
      PS_DIV6 = 2'b10,
      PS_RSVD = 2'b11
   } ocd_ps_ratio_t;
   localparam logic [2:0] PS_CNT4 = 3'h3;
   localparam logic [2:0] PS_CNT5 = 3'h4;
   localparam logic [2:0] PS_CNT6 = 3'h5;

   typedef enum logic [1:0] {
      SRC_PSA  = 2'b00,
      SRC_PSB  = 2'b01,
      SRC_REF  = 2'b10,
      SRC_REF2 = 2'b11
   } ocd_src_t;

   localparam logic [DIV_W-1:0] DIV_MIN = 14'h0002;

   typedef struct packed {
      logic       hcsl_on;
      logic       lvds_on;
      logic       cmos_p_on;
      logic       cmos_n_on;
      logic [3:0] edge_rate;
      logic [3:0] bias_trim;
      logic [1:0] cm_raise;
      logic [1:0] cm_lower;
   } ocd_chan_cfg_t;

endpackage : ocd_pkg

// [logic/ocd_prescaler.sv]
module ocd_prescaler
   import ocd_pkg::*;
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_reset,
   input  wire logic       i_vco_tick,
   input  wire logic [1:0] i_ratio,
   output logic            o_tick
);

   typedef struct packed {
      logic [2:0] cnt;
      logic       tick;
   } ocd_ps_state_t;

   ocd_ps_state_t st_ff;
   ocd_ps_state_t nxt_st;
   logic [2:0]    last;

   always_comb begin
      unique case (ocd_ps_ratio_t'(i_ratio))
         PS_DIV4: last = PS_CNT4;
         PS_DIV5: last = PS_CNT5;
         PS_DIV6: last = PS_CNT6;
         PS_RSVD: last = PS_CNT6;
      endcase
      nxt_st      = st_ff;
      nxt_st.tick = 1'b0;
      if (i_vco_tick) begin
         // One tick out per four, five or six VCO periods
         if (st_ff.cnt >= last) begin // RQ1
            nxt_st.cnt  = 3'h0;
            nxt_st.tick = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_tick = st_ff.tick;

endmodule : ocd_prescaler

// [logic/ocd_int_divider.sv]
module ocd_int_divider
   import ocd_pkg::*;
(
   input  wire logic             i_clk_sys,
   input  wire logic             i_reset,
   input  wire logic             i_tick,
   input  wire logic [DIV_W+1:0] i_cfg,
   input  wire logic             i_smooth,
   output logic                  o_clk
);

   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic [DIV_W+1:0] cfg;
      logic             clk;
   } ocd_div_state_t;

   ocd_div_state_t   st_ff;
   ocd_div_state_t   nxt_st;
   logic [DIV_W-1:0] eff;
   logic [DIV_W-1:0] nxt_eff;

   always_comb begin
      nxt_st = st_ff;
      eff    = (st_ff.cfg[DIV_W-1:0] < DIV_MIN) ? DIV_MIN
             : st_ff.cfg[DIV_W-1:0];
      if (i_cfg != st_ff.cfg && !i_smooth) begin
         // Abrupt change: restart at once, a low pulse may be cut
         nxt_st.cnt = '0;
         nxt_st.cfg = i_cfg;
      end else if (i_tick) begin
         if (st_ff.cnt >= eff - DIV_MIN / 2) begin // RQ23
            nxt_st.cnt = '0;
            // New setting only at a period boundary, high kept whole
            nxt_st.cfg = i_cfg; // RQ20
         end else begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
         end
      end
      nxt_eff = (nxt_st.cfg[DIV_W-1:0] < DIV_MIN) ? DIV_MIN
              : nxt_st.cfg[DIV_W-1:0];
      // High for the first half of each period
      nxt_st.clk = nxt_st.cnt < (nxt_eff >> 1); // RQ3 RQ23
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_clk = st_ff.clk;

endmodule : ocd_int_divider

// [logic/ocd_distribution.sv]
module ocd_distribution
   import ocd_pkg::*;
(
   input  wire logic                    i_clk_sys,
   input  wire logic                    i_reset,
   input  wire logic                    i_vco_tick,
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_pfd_clk,
   input  wire logic [NCH-1:0]          i_low_supply,
   input  wire ocd_addr_t               i_reg_addr,
   input  wire ocd_word_t               i_reg_wdata,
   input  wire logic                    i_reg_wr,
   input  wire logic                    i_reg_rd,
   output ocd_word_t                    o_reg_rdata,
   output logic                         o_reg_rvalid,
   output logic                         o_output_zero,
   output logic                         o_output_zero_on,
   output logic [3:0]                   o_output_zero_edge_rate,
   output logic [NCH-1:0]               o_out_p,
   output logic [NCH-1:0]               o_out_n,
   output ocd_chan_cfg_t [NCH-1:0]      o_chan_cfg
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      ocd_regs_t                 regs;
      logic                      ref_q;
      ocd_word_t                 rdata;
      logic                      rvalid;
      logic                      output_zero;
      logic                      output_zero_on;
      logic [3:0]                output_zero_rate;
      logic [NCH-1:0]            out_p;
      logic [NCH-1:0]            out_n;
      ocd_chan_cfg_t [NCH-1:0]   cfg;
   } ocd_state_t;

   ocd_state_t     st_ff;
   ocd_state_t     nxt_st;
   logic           psa_tick;
   logic           psb_tick;
   logic           ref_tick;
   logic [NCH-1:0] src_tick;
   logic [NCH-1:0] div_clk;
   logic [NCH-1:0] smooth;

   assign ref_tick = i_ref_clk & ~st_ff.ref_q;

   // ****************************************
   // Prescalers
   // ****************************************
   ocd_prescaler u_prescaler_a (
      .i_clk_sys  (i_clk_sys),
      .i_reset    (i_reset),
      .i_vco_tick (i_vco_tick),
      .i_ratio    (st_ff.regs[IX_PRESCALE][PSA_LSB +: 2]), // RQ2
      .o_tick     (psa_tick)
   );

   ocd_prescaler u_prescaler_b (
      .i_clk_sys  (i_clk_sys),
      .i_reset    (i_reset),
      .i_vco_tick (i_vco_tick),
      .i_ratio    (st_ff.regs[IX_PRESCALE][PSB_LSB +: 2]), // RQ2
      .o_tick     (psb_tick)
   );

   // ****************************************
   // Channel integer dividers
   // ****************************************
   for (genvar g = 0; g < NCH; g++) begin : g_chan
      always_comb begin
         unique case (ocd_src_t'(st_ff.regs[IX_SRC[g]][SRC_LSB +: 2]))
            SRC_PSA:  src_tick[g] = psa_tick; // RQ4
            SRC_PSB:  src_tick[g] = psb_tick;
            SRC_REF:  src_tick[g] = ref_tick;
            SRC_REF2: src_tick[g] = ref_tick;
         endcase
      end

      assign smooth[g] = st_ff.regs[IX_CTLA[g]][SMOOTH_BIT]; // RQ22

      ocd_int_divider u_divider (
         .i_clk_sys (i_clk_sys),
         .i_reset   (i_reset),
         .i_tick    (src_tick[g]),
         .i_cfg     (st_ff.regs[IX_SRC[g]]), // RQ7
         .i_smooth  (smooth[g]),
         .o_clk     (div_clk[g])
      );
   end

   // ****************************************
   // Registers and output stage
   // ****************************************
   always_comb begin
      logic clk;
      logic diff_on;
      logic pol_p;
      logic pol_n;
      clk     = 1'b0;
      diff_on = 1'b0;
      pol_p   = 1'b0;
      pol_n   = 1'b0;
      nxt_st        = st_ff;
      nxt_st.ref_q  = i_ref_clk;
      nxt_st.rvalid = i_reg_rd;
      if (i_reg_rd) begin
         nxt_st.rdata = '0;
      end
      for (int r = 0; r < NREG; r++) begin
         if (i_reg_addr == REG_ADDR[r]) begin
            if (i_reg_wr) begin
               nxt_st.regs[r] = i_reg_wdata;
            end
            if (i_reg_rd) begin
               nxt_st.rdata = st_ff.regs[r];
            end
         end
      end

      // Output zero, a plain copy of reference or phase detector clock
      nxt_st.output_zero_on   = st_ff.regs[IX_OUTPUT_ZERO_EN][OUTPUT_ZERO_ON_BIT]; // RQ13
      nxt_st.output_zero_rate = st_ff.regs[IX_OUTPUT_ZERO_SLEW][SLEW_LSB +: 4]; // RQ13
      nxt_st.output_zero = st_ff.regs[IX_REF_ROUTE][OUTPUT_ZERO_PATH_BIT] // RQ6
                  & st_ff.regs[IX_OUTPUT_ZERO_EN][OUTPUT_ZERO_ON_BIT] // RQ13
                  & (st_ff.regs[IX_REF_ROUTE][OUTPUT_ZERO_SRC_BIT] ? i_ref_clk
                                                           : i_pfd_clk);

      for (int i = 0; i < NCH; i++) begin
         // Bypass skips the divider and its one-cycle lag
         clk = st_ff.regs[IX_REF_ROUTE][BYPASS_LSB + i] ? i_ref_clk // RQ5
             : div_clk[i];
         nxt_st.cfg[i].hcsl_on = st_ff.regs[IX_CTLA[i]][HCSL_BIT[i]]; // RQ15
         nxt_st.cfg[i].lvds_on = st_ff.regs[IX_CTLB[i]][LVDS_BIT[i]]; // RQ16
         nxt_st.cfg[i].bias_trim =
            st_ff.regs[IX_TRIM[i]][BIAS_LSB[i] +: 4]; // RQ17
         // Common mode trims are forced off in 1.8 V mode
         nxt_st.cfg[i].cm_raise = i_low_supply[i] ? 2'h0
            : st_ff.regs[IX_TRIM[i]][CMUP_LSB[i] +: 2]; // RQ18
         nxt_st.cfg[i].cm_lower = i_low_supply[i] ? 2'h0
            : st_ff.regs[IX_CMDN[i]][CMDN_LSB[i] +: 2]; // RQ18
         if (CMOS_OK[i]) begin // RQ8
            nxt_st.cfg[i].cmos_p_on =
               st_ff.regs[IX_CTLB[i]][PEN_BIT[i]]; // RQ11
            nxt_st.cfg[i].cmos_n_on =
               st_ff.regs[IX_CTLB[i]][NEN_BIT[i]]; // RQ11
            nxt_st.cfg[i].edge_rate =
               st_ff.regs[IX_TRIM[i]][SLEW_LSB +: 4]; // RQ14
            pol_p = st_ff.regs[IX_CTLB[i]][PPOL_BIT[i]];
            pol_n = st_ff.regs[IX_CTLB[i]][NPOL_BIT[i]];
         end else begin
            // No single-ended buffer on the inner outputs
            nxt_st.cfg[i].cmos_p_on = 1'b0; // RQ9
            nxt_st.cfg[i].cmos_n_on = 1'b0; // RQ9
            nxt_st.cfg[i].edge_rate = 4'h0;
            pol_p = 1'b0;
            pol_n = 1'b0;
         end
         // Differential wins if software enables several types at once
         diff_on = nxt_st.cfg[i].hcsl_on | nxt_st.cfg[i].lvds_on; // RQ10
         if (diff_on) begin
            nxt_st.out_p[i] = clk;
            nxt_st.out_n[i] = ~clk;
         end else begin
            nxt_st.out_p[i] = nxt_st.cfg[i].cmos_p_on & (clk ^ pol_p); // RQ12
            nxt_st.out_n[i] = nxt_st.cfg[i].cmos_n_on & (clk ^ pol_n); // RQ12
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         st_ff      <= '0;
         st_ff.regs <= {NREG{REG_RESET}};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_reg_rdata      = st_ff.rdata;
   assign o_reg_rvalid     = st_ff.rvalid;
   assign o_output_zero           = st_ff.output_zero;
   assign o_output_zero_on        = st_ff.output_zero_on;
   assign o_output_zero_edge_rate = st_ff.output_zero_rate;
   assign o_out_p          = st_ff.out_p;
   assign o_out_n          = st_ff.out_n;
   assign o_chan_cfg       = st_ff.cfg;

endmodule : ocd_distribution

// [bench/ocd_clk_rx.sv]
// ****************************************
// Board clock receiver
// ****************************************
module ocd_clk_rx (
   input  wire logic  i_clk_sys,
   input  wire logic  i_pin,
   input  wire logic  i_clr,
   output logic [15:0] o_per,
   output logic [15:0] o_hi,
   output logic [15:0] o_min_hi,
   output int unsigned o_edges
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] cnt = '0;
   logic [15:0] hc  = '0;
   logic        lst = 1'b0;
   initial o_edges = 0;
   // Period in system cycles, rise to rise
   always @(posedge i_clk_sys) begin
      lst <= i_pin;
      cnt <= cnt + 16'h0001;
      if (i_pin) begin
         hc <= hc + 16'h0001;
      end
      if (i_pin && !lst) begin
         o_per   <= cnt;
         cnt     <= 16'h0001;
         o_edges <= o_edges + 1;
      end
      if (!i_pin && lst) begin
         o_hi <= hc;
         hc   <= 16'h0000;
         if (hc < o_min_hi) begin
            o_min_hi <= hc;
         end
      end
      if (i_clr) begin
         o_min_hi <= 16'hffff;
      end
   end
endmodule : ocd_clk_rx

// [bench/ocd_distribution_chk.sv]
// ****************************************
// Port checker
// ****************************************
module ocd_distribution_chk
   import ocd_pkg::*;
(
   input wire logic                    i_clk_sys,
   input wire logic                    i_reset,
   input wire logic [NCH-1:0]          i_low_supply,
   input wire ocd_addr_t               i_reg_addr,
   input wire ocd_word_t               i_reg_wdata,
   input wire logic                    i_reg_wr,
   input wire logic                    i_reg_rd,
   input wire ocd_word_t               o_reg_rdata,
   input wire logic                    o_reg_rvalid,
   input wire logic                    o_output_zero,
   input wire logic                    o_output_zero_on,
   input wire logic [3:0]              o_output_zero_edge_rate,
   input wire logic [NCH-1:0]          o_out_p,
   input wire logic [NCH-1:0]          o_out_n,
   input wire ocd_chan_cfg_t [NCH-1:0] o_chan_cfg
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   AST_RVALID: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read not answered");
   AST_NORV: assert property (!i_reg_rd |=> !o_reg_rvalid)
      else $error("spurious read answer");
   AST_UNMAP: assert property (i_reg_rd && i_reg_addr == 7'h7f
      |=> o_reg_rdata == 16'h0000) else $error("unmapped read not zero");
   AST_SE23: assert property (!(|{o_chan_cfg[1].cmos_p_on,
      o_chan_cfg[1].cmos_n_on, o_chan_cfg[2].cmos_p_on,
      o_chan_cfg[2].cmos_n_on})) else $error("single-ended on 2 or 3");
   AST_OUT0OFF: assert property (!o_output_zero_on && $past(!o_output_zero_on)
      |-> !o_output_zero) else $error("output zero runs while off");
   AST_SLEW0: assert property (i_reg_wr && i_reg_addr == 7'h4f
      |-> ##2 o_output_zero_edge_rate == $past(i_reg_wdata[3:0], 2))
      else $error("output zero edge rate wrong");
   AST_SLEW1: assert property (i_reg_wr && i_reg_addr == 7'h3c
      |-> ##2 o_chan_cfg[0].edge_rate == $past(i_reg_wdata[3:0], 2))
      else $error("output one edge rate wrong");
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      AST_DIFF: assert property ((o_chan_cfg[i].hcsl_on
         || o_chan_cfg[i].lvds_on) && $stable(o_chan_cfg[i])
         && o_chan_cfg[i] == $past(o_chan_cfg[i], 2)
         |-> o_out_n[i] != o_out_p[i]) else $error("pins not opposite");
      AST_CMLOW: assert property (i_low_supply[i]
         && $past(i_low_supply[i]) |-> o_chan_cfg[i].cm_raise == 2'b00
         && o_chan_cfg[i].cm_lower == 2'b00)
         else $error("common mode trim at low supply");
   end
   COV_RD: cover property (o_reg_rvalid && o_reg_rdata != 16'h0000);
   COV_OUTPUT_ZERO: cover property ($rose(o_output_zero));
   COV_P1: cover property ($rose(o_out_p[0]) && o_chan_cfg[0].hcsl_on);
endmodule : ocd_distribution_chk
bind ocd_distribution ocd_distribution_chk ocd_distribution_chk_inst (
   .i_clk_sys, .i_reset, .i_low_supply, .i_reg_addr, .i_reg_wdata,
   .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .o_output_zero,
   .o_output_zero_on, .o_output_zero_edge_rate, .o_out_p, .o_out_n, .o_chan_cfg);

// [bench/ocd_distribution_tb_top.sv]
module ocd_distribution_tb_top
   import ocd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Stimulus and design
   // ****************************************
   logic i_clk_sys = 0, i_reset = 1, i_vco_tick = 1;
   logic i_ref_clk = 0, i_pfd_clk = 0, clr = 0;
   logic [NCH-1:0] i_low_supply = '0;
   ocd_addr_t i_reg_addr = '0;
   ocd_word_t i_reg_wdata = '0;
   logic i_reg_wr = 0, i_reg_rd = 0;
   ocd_word_t o_reg_rdata;
   logic o_reg_rvalid, o_output_zero, o_output_zero_on;
   logic [3:0] o_output_zero_edge_rate;
   logic [NCH-1:0] o_out_p, o_out_n;
   ocd_chan_cfg_t [NCH-1:0] o_chan_cfg;
   logic [15:0] per [2], hi [2], mh [2];
   int unsigned ed [2];
   ocd_word_t exq [$];
   int miscompares = 0, compares = 0, n, rt;
   ocd_word_t d;
   always #5 i_clk_sys = ~i_clk_sys;
   // Toggles land on falling edges: ref period 6, pfd 10 cycles
   always #30 i_ref_clk = ~i_ref_clk;
   always #50 i_pfd_clk = ~i_pfd_clk;
   ocd_distribution ocd_distribution_inst (.i_clk_sys, .i_reset,
      .i_vco_tick, .i_ref_clk, .i_pfd_clk, .i_low_supply, .i_reg_addr,
      .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid,
      .o_output_zero, .o_output_zero_on, .o_output_zero_edge_rate, .o_out_p, .o_out_n,
      .o_chan_cfg);
   ocd_clk_rx ocd_clk_rx_inst0 (.i_clk_sys, .i_pin(o_output_zero), .i_clr(clr),
      .o_per(per[0]), .o_hi(hi[0]), .o_min_hi(mh[0]), .o_edges(ed[0]));
   ocd_clk_rx ocd_clk_rx_inst1 (.i_clk_sys, .i_pin(o_out_p[0]),
      .i_clr(clr), .o_per(per[1]), .o_hi(hi[1]), .o_min_hi(mh[1]),
      .o_edges(ed[1]));
   task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic results();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   task automatic wr(ocd_addr_t a, ocd_word_t v);
      @(negedge i_clk_sys);
      i_reg_addr = a;
      i_reg_wdata = v;
      i_reg_wr = 1;
      @(negedge i_clk_sys);
      i_reg_wr = 0;
   endtask : wr
   task automatic rd(ocd_addr_t a, ocd_word_t e);
      @(negedge i_clk_sys);
      i_reg_addr = a;
      i_reg_rd = 1;
      exq.push_back(e);
      @(negedge i_clk_sys);
      i_reg_rd = 0;
   endtask : rd
   // Settle past the restart period, then judge the latest one
   task automatic meas(int s, int p, int h);
      int unsigned e;
      e = ed[s];
      for (int k = 0; k < 2000 && ed[s] < e + 3; k++) @(negedge i_clk_sys);
      chk("period", per[s], 16'(p));
      chk("high time", hi[s], 16'(h));
   endtask : meas
   always @(negedge i_clk_sys) begin
      if (o_reg_rvalid === 1'b1) begin
         if (exq.size() == 0) chk("answer count", 16'h1, 16'h0);
         else chk("rdata", o_reg_rdata, exq.pop_front());
      end
   end
   initial begin
      #400us;
      miscompares++;
      results();
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      void'($urandom(32'hac2b));
      repeat (4) @(negedge i_clk_sys);
      i_reset = 0;
      for (int i = 0; i < NREG; i++) rd(REG_ADDR[i], REG_RESET);
      // Random words are cleared at once to keep one buffer per output
      for (int i = 0; i < NREG; i++) begin
         d = ocd_word_t'($urandom);
         // Only one buffer type at a time on the outer outputs
         if (i == IX_CH1_CTLB || i == IX_CH4_CTLB) begin
            d[14:13] = 2'b00;
         end
         wr(REG_ADDR[i], d);
         rd(REG_ADDR[i], d);
         wr(REG_ADDR[i], 16'h0000);
      end
      wr(7'h7f, 16'hffff);
      rd(7'h7f, 16'h0000);
      wr(7'h39, 16'h4000);
      for (int s = 0; s < 4; s++) begin
         for (int r = 0; r < 3; r++) begin
            n = $urandom_range(2, 9);
            rt = (s == 0) ? 4 + r : (s == 1) ? 4 + (r + 1) % 3 : 6;
            wr(7'h2f, 16'(r << 3 | ((r + 1) % 3) << 5));
            wr(7'h38, {2'(s), 14'(n)});
            meas(1, n * rt, (n / 2) * rt);
         end
      end
      wr(7'h39, 16'h0000);
      wr(7'h3b, 16'h8000);
      meas(1, n * 6, (n / 2) * 6);
      wr(7'h19, 16'h0800);
      meas(1, 6, 3);
      wr(7'h19, 16'h0000);
      wr(7'h4e, 16'h1000);
      wr(7'h4f, 16'h0009);
      wr(7'h19, 16'h0600);
      meas(0, 6, 3);
      chk("output_zero on", 16'(o_output_zero_on), 16'h1);
      chk("output_zero rate", 16'(o_output_zero_edge_rate), 16'h9);
      wr(7'h19, 16'h0400);
      meas(0, 10, 5);
      wr(7'h4e, 16'h0000);
      wr(7'h3b, 16'h0000);
      wr(7'h39, 16'h4200);
      wr(7'h2f, 16'h0000);
      wr(7'h38, 16'h0008);
      meas(1, 32, 16);
      @(posedge o_out_p[0]);
      // Land the update late in the high phase, where a cut would show
      repeat (10) @(negedge i_clk_sys);
      clr = 1;
      wr(7'h38, 16'h0004);
      clr = 0;
      @(negedge o_out_p[0]);
      repeat (2) @(negedge i_clk_sys);
      chk("held high", hi[1], 16'd16);
      meas(1, 16, 8);
      chk("shortest high", mh[1], 16'd8);
      wr(7'h39, 16'h0000);
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < 4; k++) begin
            wr(c ? 7'h4b : 7'h3b, 16'(16'h6000 | k << 11));
            repeat (5) @(negedge i_clk_sys);
            chk("pin xor", 16'(o_out_p[c*3] ^ o_out_n[c*3]), 16'(^k));
         end
         wr(c ? 7'h4b : 7'h3b, 16'h0000);
         repeat (5) @(negedge i_clk_sys);
         chk("pins off", 16'({o_out_p[c*3], o_out_n[c*3]}), 16'h0);
      end
      wr(7'h3c, 16'h0c05);
      repeat (3) @(negedge i_clk_sys);
      chk("cm raise", 16'(o_chan_cfg[0].cm_raise), 16'h3);
      chk("edge rate", 16'(o_chan_cfg[0].edge_rate), 16'h5);
      i_low_supply = 4'h1;
      repeat (3) @(negedge i_clk_sys);
      chk("cm raise low", 16'(o_chan_cfg[0].cm_raise), 16'h0);
      repeat (4) @(negedge i_clk_sys);
      results();
   end
endmodule : ocd_distribution_tb_top
